// file: hdl/lsd_fault_diag_regs.svh
// Register offsets, field positions, reset values and timing counts of the driver diagnosis block.
`ifndef LSD_FAULT_DIAG_REGS_SVH
`define LSD_FAULT_DIAG_REGS_SVH

`define LSD_CLK_PERIOD_NS    5
`define LSD_ADDR_CMD         8'h00
`define LSD_ADDR_CFG         8'h04
`define LSD_ADDR_DIAG        8'h08
`define LSD_ADDR_STAT        8'h0C
`define LSD_CFG_GDIS_BIT     0
`define LSD_CFG_LCOFF_BIT    1
`define LSD_CFG_HOLDA_BIT    2
`define LSD_CFG_HOLDB_BIT    3
`define LSD_CFG_RST          4'h0
`define LSD_STAT_HOLD_BIT    16
`define LSD_OVC_FILT_NS      4000
`define LSD_OFF_FILT_NS      50000
`define LSD_MASK_NS          300000
`define LSD_HOLD_MS          400
`define LSD_CYC_UP(ns)       (((ns) + `LSD_CLK_PERIOD_NS - 1) / `LSD_CLK_PERIOD_NS)
`define LSD_OVC_FILT_CYC     `LSD_CYC_UP(`LSD_OVC_FILT_NS)
`define LSD_OFF_FILT_CYC     `LSD_CYC_UP(`LSD_OFF_FILT_NS)
`define LSD_MASK_CYC         `LSD_CYC_UP(`LSD_MASK_NS)
`define LSD_HOLD_CYC         (`LSD_HOLD_MS * 1000000 / `LSD_CLK_PERIOD_NS)

`endif

// file: hdl/lsd_pkg.sv
// Types shared by the driver diagnosis block.
package lsd_pkg;

  typedef enum logic [1:0]
  {
    lsd_code_scg = 2'b00,
    lsd_code_ol  = 2'b01,
    lsd_code_sgb = 2'b10,
    lsd_code_ok  = 2'b11
  } lsd_code_t;

  typedef enum logic [1:0]
  {
    lsd_hold_idle    = 2'b00,
    lsd_hold_run     = 2'b01,
    lsd_hold_expired = 2'b10
  } lsd_hold_t;

endpackage

// file: hdl/lsd_fault_diag.sv
// Fault diagnosis and protection for protected low-side relay and low-current drivers.
//
// Local design decisions: the strobed register port and the register addresses.
`include "lsd_fault_diag_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module lsd_fault_diag
#(
  parameter int unsigned NUM_CH   = 7,
  parameter int unsigned LC_CH    = 6,
  parameter int unsigned OFF_CYC  = `LSD_OFF_FILT_CYC,
  parameter int unsigned MASK_CYC = `LSD_MASK_CYC,
  parameter int unsigned HOLD_CYC = `LSD_HOLD_CYC
)
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [31:0]       reg_rdata_r,
  input  wire logic [NUM_CH-1:0] ovc_cmp,
  input  wire logic [NUM_CH-1:0] below_gnd_thr,
  input  wire logic [NUM_CH-1:0] below_ol_thr,
  input  wire logic              device_reset_signal,
  input  wire logic              mcu_rst_n,
  input  wire logic              vb_low,
  output var  logic [NUM_CH-1:0] drv_on_r,
  output var  logic              lc_pull_en_r
);

  localparam int unsigned OVC_CYC = `LSD_OVC_FILT_CYC;
  localparam int unsigned OVC_W   = $clog2(OVC_CYC + 1);
  localparam int unsigned OFF_W   = $clog2(OFF_CYC + 1);
  localparam int unsigned MASK_W  = $clog2(MASK_CYC + 1);
  localparam int unsigned HOLD_W  = $clog2(HOLD_CYC + 1);
  localparam int unsigned SYN_W   = 3 * NUM_CH + 3;

  localparam logic [OVC_W-1:0]  OVC_LAST  = OVC_W'(OVC_CYC - 1);
  localparam logic [OFF_W-1:0]  OFF_LAST  = OFF_W'(OFF_CYC - 1);
  localparam logic [MASK_W-1:0] MASK_LOAD = MASK_W'(MASK_CYC);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);

  // Pin synchroniser: three stages, a change is accepted once stages two and three agree.
  logic [SYN_W-1:0] syn1_r;
  logic [SYN_W-1:0] syn2_r;
  logic [SYN_W-1:0] syn3_r;
  logic [SYN_W-1:0] pin_r;
  wire  [SYN_W-1:0] pin_raw = {vb_low, mcu_rst_n, device_reset_signal,
                               below_ol_thr, below_gnd_thr, ovc_cmp};
  wire  [SYN_W-1:0] pin_nxt = (syn2_r & syn3_r) | (pin_r & (syn2_r ^ syn3_r));

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syn1_r <= '0;
      syn2_r <= '0;
      syn3_r <= '0;
      pin_r  <= '0;
    end
    else if (clk_en)
    begin
      syn1_r <= pin_raw;
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
      pin_r  <= pin_nxt;
    end
  end

  wire [NUM_CH-1:0] ovc_f     = pin_r[NUM_CH-1:0];
  wire [NUM_CH-1:0] low_f     = pin_r[2*NUM_CH-1:NUM_CH];
  wire [NUM_CH-1:0] high_f    = pin_r[3*NUM_CH-1:2*NUM_CH];
  wire              dev_rst_f = pin_r[3*NUM_CH];
  wire              mcu_rst_f = pin_r[3*NUM_CH+1];
  wire              vb_low_f  = pin_r[3*NUM_CH+2];

  // Register file.
  logic [NUM_CH-1:0] cmd_r;
  logic [3:0]        cfg_r;
  logic [1:0]        code_r [NUM_CH];

  wire sel_cmd  = (reg_addr == `LSD_ADDR_CMD);
  wire sel_cfg  = (reg_addr == `LSD_ADDR_CFG);
  wire sel_diag = (reg_addr == `LSD_ADDR_DIAG);
  wire sel_stat = (reg_addr == `LSD_ADDR_STAT);
  wire diag_rd  = reg_rd & sel_diag;
  wire gdis     = cfg_r[`LSD_CFG_GDIS_BIT];
  wire lcoff    = cfg_r[`LSD_CFG_LCOFF_BIT];
  wire force_off = gdis | dev_rst_f;

  logic [2*NUM_CH-1:0] codes_flat;
  always_comb
  begin
    codes_flat = '0;
    for (int k = 0; k < NUM_CH; k++)
    begin
      codes_flat[2*k +: 2] = code_r[k];
    end
  end

  // Low-battery hold of the two capable relay outputs.
  lsd_pkg::lsd_hold_t hold_st_r;
  lsd_pkg::lsd_hold_t hold_st_nxt;
  logic [HOLD_W-1:0]  hold_cnt_r;
  logic [1:0]         hold_keep_r;
  logic               mcu_rst_prev_r;

  wire       rst_fall = mcu_rst_prev_r & ~mcu_rst_f;
  wire [1:0] keep_cap = {cfg_r[`LSD_CFG_HOLDB_BIT] & drv_on_r[1],
                         cfg_r[`LSD_CFG_HOLDA_BIT] & drv_on_r[0]};
  wire       hold_on  = (hold_st_r == lsd_pkg::lsd_hold_run);
  wire       hold_act = (hold_st_r != lsd_pkg::lsd_hold_idle);
  // Taking over on the trigger cycle itself keeps the relay from dropping for one cycle.
  wire       hold_go  = (hold_st_r == lsd_pkg::lsd_hold_idle) & rst_fall & vb_low_f;
  wire [NUM_CH-1:0] held = {{(NUM_CH-2){1'b0}},
                            (hold_keep_r & {2{hold_act}}) | (keep_cap & {2{hold_go}})};

  always_comb
  begin
    hold_st_nxt = hold_st_r;
    unique case (hold_st_r)
      lsd_pkg::lsd_hold_idle:
      begin
        if (rst_fall && vb_low_f && (keep_cap != 2'b00))
        begin
          hold_st_nxt = lsd_pkg::lsd_hold_run;
        end
      end
      lsd_pkg::lsd_hold_run:
      begin
        if (mcu_rst_f)
        begin
          hold_st_nxt = lsd_pkg::lsd_hold_idle;
        end
        else if (hold_cnt_r == HOLD_LAST)
        begin
          hold_st_nxt = lsd_pkg::lsd_hold_expired;
        end
      end
      lsd_pkg::lsd_hold_expired:
      begin
        if (mcu_rst_f)
        begin
          hold_st_nxt = lsd_pkg::lsd_hold_idle;
        end
      end
      default:
      begin
        hold_st_nxt = lsd_pkg::lsd_hold_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_st_r      <= lsd_pkg::lsd_hold_idle;
      hold_cnt_r     <= '0;
      hold_keep_r    <= 2'h0;
      mcu_rst_prev_r <= 1'b0;
    end
    else if (clk_en)
    begin
      hold_st_r      <= hold_st_nxt;
      mcu_rst_prev_r <= mcu_rst_f;
      hold_cnt_r     <= hold_on ? hold_cnt_r + HOLD_W'(1) : '0;
      if (hold_st_r == lsd_pkg::lsd_hold_idle)
      begin
        hold_keep_r <= keep_cap;
      end
    end
  end

  // Per-channel protection and diagnosis.
  logic [NUM_CH-1:0] drv_nxt;
  logic [NUM_CH-1:0] trip_r;
  logic [OVC_W-1:0]  ovc_cnt_r  [NUM_CH];
  logic [OFF_W-1:0]  off_cnt_r  [NUM_CH];
  logic [MASK_W-1:0] mask_cnt_r [NUM_CH];
  logic [1:0]        cls_r      [NUM_CH];

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    wire       on_cmd   = cmd_r[i] & ~force_off;
    wire       ovc_act  = drv_on_r[i] & ovc_f[i];
    wire       ovc_hit  = ovc_act & (ovc_cnt_r[i] == OVC_LAST);
    wire       trip_nxt = ovc_hit | (trip_r[i] & on_cmd & ~diag_rd);
    wire       lc_dis   = (i == LC_CH) & lcoff;
    wire       off_act  = ~on_cmd & ~drv_on_r[i] & (mask_cnt_r[i] == '0) & ~lc_dis;
    wire [1:0] cls      = low_f[i]  ? lsd_pkg::lsd_code_scg :
                          high_f[i] ? lsd_pkg::lsd_code_ol  :
                                      lsd_pkg::lsd_code_ok;
    wire       off_bad  = off_act & (cls != lsd_pkg::lsd_code_ok);
    wire       same_cls = (cls == cls_r[i]);
    wire       off_hit  = off_bad & same_cls & (off_cnt_r[i] == OFF_LAST);
    wire       first    = (code_r[i] == lsd_pkg::lsd_code_ok) | diag_rd;

    assign drv_nxt[i] = held[i] ? (hold_on | hold_go) : (on_cmd & ~trip_nxt);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        trip_r[i]     <= 1'b0;
        ovc_cnt_r[i]  <= '0;
        off_cnt_r[i]  <= '0;
        mask_cnt_r[i] <= '0;
        cls_r[i]      <= lsd_pkg::lsd_code_ok;
        code_r[i]     <= lsd_pkg::lsd_code_ok;
      end
      else if (clk_en)
      begin
        trip_r[i] <= trip_nxt;
        cls_r[i]  <= cls;
        // Filters restart as soon as the watched condition drops or changes class.
        ovc_cnt_r[i] <= (ovc_act && !ovc_hit) ? ovc_cnt_r[i] + OVC_W'(1) : '0;
        if (!off_bad || !same_cls)
        begin
          off_cnt_r[i] <= '0;
        end
        else if (off_cnt_r[i] != OFF_LAST)
        begin
          off_cnt_r[i] <= off_cnt_r[i] + OFF_W'(1);
        end
        if (drv_on_r[i] && !drv_nxt[i])
        begin
          mask_cnt_r[i] <= MASK_LOAD;
        end
        else if (mask_cnt_r[i] != '0)
        begin
          mask_cnt_r[i] <= mask_cnt_r[i] - MASK_W'(1);
        end
        // A new fault wins over a read-diagnosis clear in the same cycle.
        if (ovc_hit)
        begin
          code_r[i] <= lsd_pkg::lsd_code_sgb;
        end
        else if (off_hit && first)
        begin
          code_r[i] <= cls;
        end
        else if (diag_rd)
        begin
          code_r[i] <= lsd_pkg::lsd_code_ok;
        end
      end
    end
  end

  // Register writes, read data and driver outputs.
  wire [31:0] rd_mux =
    sel_cmd  ? 32'(cmd_r) :
    sel_cfg  ? 32'(cfg_r) :
    sel_diag ? 32'(codes_flat) :
    sel_stat ? (32'(drv_on_r) | (32'(hold_act) << `LSD_STAT_HOLD_BIT)) :
               32'h0000_0000;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_r        <= '0;
      cfg_r        <= `LSD_CFG_RST;
      reg_rdata_r  <= 32'h0000_0000;
      drv_on_r     <= '0;
      lc_pull_en_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (reg_wr && sel_cmd)
      begin
        cmd_r <= reg_wdata[NUM_CH-1:0];
      end
      if (reg_wr && sel_cfg)
      begin
        cfg_r <= reg_wdata[3:0];
      end
      reg_rdata_r  <= reg_rd ? rd_mux : 32'h0000_0000;
      drv_on_r     <= drv_nxt;
      lc_pull_en_r <= ~lcoff;
    end
  end

endmodule

`default_nettype wire

// file: dv/lsd_load_model.sv
// Behavioural loads on the low-side outputs.
`timescale 1ns/100ps
`default_nettype none
module lsd_load_model
(
  input  wire logic [6:0]      drv_on_r,
  input  wire logic [6:0][1:0] mode,
  output logic [6:0]           ovc_cmp,
  output logic [6:0]           below_gnd_thr,
  output logic [6:0]           below_ol_thr
);
  // Mode 1 ground short, 2 open line, 3 battery short. A driven output sits near ground.
  always_comb
  begin
    for (int k = 0; k < 7; k++)
    begin
      ovc_cmp[k] = drv_on_r[k] && mode[k] == 2'h3;
      below_gnd_thr[k] = drv_on_r[k] || mode[k] == 2'h1;
      below_ol_thr[k] = drv_on_r[k] || mode[k] == 2'h1 || mode[k] == 2'h2;
    end
  end
endmodule
`default_nettype wire

// file: dv/lsd_diag_properties.sv
// Port checks for the driver diagnosis block.
`include "lsd_fault_diag_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module lsd_diag_checker
#(
  parameter int unsigned NUM_CH   = 7,
  parameter int unsigned HOLD_CYC = 50
)
(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata_r,
  input wire logic [NUM_CH-1:0] ovc_cmp,
  input wire logic              device_reset_signal,
  input wire logic              mcu_rst_n,
  input wire logic [NUM_CH-1:0] drv_on_r,
  input wire logic              lc_pull_en_r
);
  logic [9:0]  ovc_cnt_r;
  logic [15:0] low_cnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Both counters saturate so a stuck output keeps failing instead of wrapping.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovc_cnt_r <= 10'h0;
      low_cnt_r <= 16'h0;
    end
    else
    begin
      ovc_cnt_r <= (ovc_cmp[5] && drv_on_r[5]) ? ovc_cnt_r + 10'(ovc_cnt_r != 10'h3FF) : 10'h0;
      low_cnt_r <= !mcu_rst_n ? low_cnt_r + 16'(low_cnt_r != 16'hFFFF) : 16'h0;
    end
  end
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
    else $error("read data outside the answer cycle");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata_r == 32'h0)
    else $error("unmapped read not zero");
  stat_mirror_a: assert property (reg_rd && reg_addr == `LSD_ADDR_STAT
    |=> reg_rdata_r[NUM_CH-1:0] == $past(drv_on_r)) else $error("status differs from drivers");
  pull_cfg_a: assert property (reg_wr && reg_addr == `LSD_ADDR_CFG
    |-> ##2 lc_pull_en_r == !$past(reg_wdata[1], 2)) else $error("pull enable wrong");
  cmd_off_a: assert property (reg_wr && reg_addr == `LSD_ADDR_CMD
    |-> ##2 (drv_on_r[5:2] & ~$past(reg_wdata[5:2], 2)) == 4'h0) else $error("driver stays on");
  reset_off_a: assert property ((device_reset_signal && mcu_rst_n) [*8]
    |-> drv_on_r[5:0] == 6'h0) else $error("relay on during reset");
  ovc_trip_a: assert property (ovc_cnt_r <= 10'd808)
    else $error("overcurrent not cut off");
  hold_end_a: assert property (!(low_cnt_r > HOLD_CYC + 12 && drv_on_r[0]))
    else $error("hold outlasts its time");
  trip_c: cover property (ovc_cmp[5] && $fell(drv_on_r[5]));
  hold_c: cover property (device_reset_signal && !mcu_rst_n && drv_on_r[0]);
  diag_c: cover property (reg_rd && reg_addr == `LSD_ADDR_DIAG);
endmodule
bind lsd_fault_diag lsd_diag_checker #(.NUM_CH(NUM_CH), .HOLD_CYC(HOLD_CYC)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .ovc_cmp(ovc_cmp),
  .device_reset_signal(device_reset_signal), .mcu_rst_n(mcu_rst_n),
  .drv_on_r(drv_on_r), .lc_pull_en_r(lc_pull_en_r));
`default_nettype wire

// file: dv/lsd_fault_diag_bench.sv
// Directed bench for the driver diagnosis block with loads on its outputs.
`include "lsd_fault_diag_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module lsd_fault_diag_bench;
  logic            ref_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [7:0]      reg_addr = 8'h0;
  logic [31:0]     reg_wdata = 32'h0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            clk_en = 1'b1;
  logic            dev_rst = 1'b0;
  logic            mcu_rst_n = 1'b1;
  logic            vb_low = 1'b0;
  logic [6:0][1:0] mode = 14'h0;
  logic [31:0]     q;
  wire [31:0]      rdata;
  wire [6:0]       drv, ovc, gnd, ol;
  wire             pull;
  int              error_cnt = 0;
  int              checks_done = 0;
  int              cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  lsd_fault_diag #(.OFF_CYC(20), .MASK_CYC(30), .HOLD_CYC(50)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata),
    .ovc_cmp(ovc), .below_gnd_thr(gnd), .below_ol_thr(ol), .device_reset_signal(dev_rst),
    .mcu_rst_n(mcu_rst_n), .vb_low(vb_low), .drv_on_r(drv), .lc_pull_en_r(pull));
  lsd_load_model load (.drv_on_r(drv), .mode(mode), .ovc_cmp(ovc), .below_gnd_thr(gnd),
    .below_ol_thr(ol));
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Waits end 1 ns past the edge so that sampled outputs have settled.
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    q = rdata;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] dx(input int k, input lsd_pkg::lsd_code_t c);
    dx = (32'h3FFF & ~(32'h3 << 2 * k)) | (32'(c) << 2 * k);
  endfunction
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    tk(5);
    reset_n <= 1'b1;
    tk(2);
    chk(32'(pull), 32'h1);
    clk_en <= 1'b0;
    wr(`LSD_ADDR_CMD, 32'h7F);
    tk(1);
    clk_en <= 1'b1;
    rd(`LSD_ADDR_CMD);
    chk(q, 32'h0);
    rd(`LSD_ADDR_CFG);
    chk(q, 32'h0);
    rd(8'h10);
    chk(q, 32'h0);
    mode[2] <= 2'h1;
    mode[3] <= 2'h2;
    wr(`LSD_ADDR_CMD, 32'h7F);
    tk(5);
    rd(`LSD_ADDR_DIAG);
    chk(q, 32'h3FFF);
    wr(`LSD_ADDR_CMD, 32'h0);
    tk(40);
    rd(`LSD_ADDR_DIAG);
    chk(q, 32'h3FFF);
    tk(30);
    mode[3] <= 2'h1;
    tk(30);
    rd(`LSD_ADDR_DIAG);
    chk(q, dx(2, lsd_pkg::lsd_code_scg) & dx(3, lsd_pkg::lsd_code_ol));
    mode <= 14'h0;
    tk(10);
    rd(`LSD_ADDR_DIAG);
    rd(`LSD_ADDR_DIAG);
    chk(q, 32'h3FFF);
    $display("off-state test done");
    wr(`LSD_ADDR_CMD, 32'h24);
    mode[2] <= 2'h1;
    mode[5] <= 2'h3;
    tk(790);
    chk(32'(drv[5]), 32'h1);
    tk(20);
    chk(32'(drv[5]), 32'h0);
    rd(`LSD_ADDR_DIAG);
    chk(q, dx(5, lsd_pkg::lsd_code_sgb));
    tk(3);
    chk(32'(drv[5]), 32'h1);
    tk(810);
    mode <= 14'h0;
    wr(`LSD_ADDR_CMD, 32'h04);
    wr(`LSD_ADDR_CMD, 32'h24);
    tk(2);
    chk(32'(drv), 32'h24);
    $display("overcurrent test done");
    mode[6] <= 2'h2;
    wr(`LSD_ADDR_CMD, 32'h0);
    rd(`LSD_ADDR_DIAG);
    wr(`LSD_ADDR_CFG, 32'h2);
    tk(2);
    chk(32'(pull), 32'h0);
    tk(80);
    rd(`LSD_ADDR_DIAG);
    chk(q, 32'h3FFF);
    wr(`LSD_ADDR_CMD, 32'h3F);
    wr(`LSD_ADDR_CFG, 32'h1);
    tk(3);
    chk(32'(drv), 32'h0);
    $display("config test done");
    wr(`LSD_ADDR_CFG, 32'h4);
    tk(3);
    vb_low <= 1'b1;
    mcu_rst_n <= 1'b0;
    dev_rst <= 1'b1;
    tk(10);
    chk(32'(drv), 32'h1);
    rd(`LSD_ADDR_STAT);
    chk(q, 32'h0001_0001);
    tk(50);
    chk(32'(drv), 32'h0);
    mcu_rst_n <= 1'b1;
    tk(12);
    chk(32'(drv), 32'h0);
    $display("hold test done");
    print_verdict();
  end
endmodule
`default_nettype wire
